// ---- logic/alu_flags_top.sv ----
// datapath top: operand decode, alu, condition flags and register port
`timescale 1ns/10ps
module alu_flags_top (
  // clock and reset
  input  wire logic             CORE_CLK,
  input  wire logic             RST,
  // instruction issue
  input  wire logic             OP_VALID,
  input  wire alu_pkg::alu_op_e OP_CODE,
  input  wire alu_pkg::addr_mode_e OP_MODE,
  input  wire logic [7:0]       OP_DST,
  input  wire logic [7:0]       OP_SRC,
  input  wire logic             OP_DST_WORK,
  output logic                  OP_READY,
  // memory load side
  output alu_pkg::mem_req_s     MEM_REQ,
  input  wire logic             MEM_ACK,
  input  wire logic [7:0]       MEM_RDATA,
  // condition outputs
  output logic [3:0]            COND,
  // register port
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [7:0]       REG_WDATA,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  output logic [7:0]            REG_RDATA
);

  localparam int unsigned W = alu_pkg::DATA_W;

  typedef struct packed {
    alu_pkg::seq_e      seq;
    logic [W-1:0]       flags;
    logic [W-1:0]       opa;
    logic [W-1:0]       opb;
    logic [W-1:0]       result;
    logic [W-1:0]       worksel;
    logic [W-1:0]       rdata;
    logic [W-1:0]       dst_addr;
    logic               collide;
    logic [5:0]         op_count;
    alu_pkg::mem_req_s  mem;
  } st_s;

  st_s st_q;
  st_s st_d;

  alu_pkg::alu_out_s  ao;
  alu_pkg::alu_op_e   cur_op;
  logic [W-1:0]       eff_dst;
  logic [W-1:0]       b_val;
  logic [W-1:0]       new_flags;
  logic [alu_pkg::ADDR_W-1:0] ptr;
  logic               ptr_step;
  logic               ptr_down;
  logic               is_mem_op;

  // ------------------------------------------------------------------
  // operand decode
  // ------------------------------------------------------------------
  function automatic logic [W-1:0] work_addr(input logic [W-1:0] base,
                                             input logic [3:0] n);
    work_addr = base | {4'h0, n};
  endfunction

  function automatic logic mem_op(input alu_pkg::alu_op_e o);
    mem_op = (o == alu_pkg::OP_PROG_LOAD_INC) || (o == alu_pkg::OP_PROG_LOAD_DEC)
          || (o == alu_pkg::OP_EXT_LOAD_INC) || (o == alu_pkg::OP_EXT_LOAD_DEC);
  endfunction

  always_comb
  begin
    // 4-bit working number maps onto the 8-bit register space
    eff_dst = OP_DST_WORK ? work_addr(st_q.worksel, OP_DST[3:0])
                          : OP_DST;
    case (OP_MODE)
      alu_pkg::AM_IMM:    b_val = OP_SRC;
      alu_pkg::AM_REG:    b_val = st_q.opb;
      alu_pkg::AM_IND:    b_val = st_q.opb;
      alu_pkg::AM_INDEX:  b_val = st_q.opb + OP_SRC;
      alu_pkg::AM_DIRECT: b_val = st_q.opb;
      alu_pkg::AM_REL:    b_val = OP_SRC;
      default:            b_val = st_q.opb;
    endcase
  end

  assign cur_op    = OP_CODE;
  assign is_mem_op = mem_op(cur_op);

  alu_core #(
    .W (W)
  ) u_core (
    .op   (cur_op),
    .a    (st_q.opa),
    .b    (b_val),
    .c_in (st_q.flags[alu_pkg::FLG_C]),
    .o    (ao)
  );

  // ------------------------------------------------------------------
  // flag generation
  // ------------------------------------------------------------------
  always_comb
  begin
    new_flags = st_q.flags;
    if (ao.flg)
    begin
      new_flags[alu_pkg::FLG_V] = ao.logic_op ? 1'b0 : ao.v;
      new_flags[alu_pkg::FLG_S] = ao.res[W-1];
      new_flags[alu_pkg::FLG_Z] = (ao.res == '0);
      if (!ao.logic_op)
        new_flags[alu_pkg::FLG_C] = ao.c;
    end
    case (cur_op)
      alu_pkg::OP_SET_CARRY:    new_flags[alu_pkg::FLG_C] = 1'b1;
      alu_pkg::OP_CLEAR_CARRY:  new_flags[alu_pkg::FLG_C] = 1'b0;
      alu_pkg::OP_INVERT_CARRY: new_flags[alu_pkg::FLG_C] = !st_q.flags[alu_pkg::FLG_C];
      default:                  new_flags = new_flags;
    endcase
  end

  // ------------------------------------------------------------------
  // sequencer and registers
  // ------------------------------------------------------------------
  always_comb
  begin
    st_d       = st_q;
    st_d.rdata = st_q.rdata;
    ptr_step   = 1'b0;
    ptr_down   = 1'b0;
    case (st_q.seq)
      alu_pkg::ST_IDLE:
      begin
        if (OP_VALID)
        begin
          st_d.dst_addr = eff_dst;
          st_d.op_count = (st_q.op_count == 6'(alu_pkg::N_INSTR - 1)) ? '0
                        : st_q.op_count + 6'h01;
          if (is_mem_op)
          begin
            st_d.mem.req  = 1'b1;
            st_d.mem.prog = (cur_op == alu_pkg::OP_PROG_LOAD_INC)
                         || (cur_op == alu_pkg::OP_PROG_LOAD_DEC);
            st_d.mem.addr = ptr;
            st_d.seq      = alu_pkg::ST_MEM;
          end
          else
          begin
            if (ao.wr)
              st_d.result = ao.res;
            st_d.flags = new_flags;
            // destination write lands on the flags register
            if (ao.wr && (eff_dst == alu_pkg::A_FLAGS))
            begin
              // undefined merge: last writer is the flag update
              st_d.collide = ao.flg;
              if (!ao.flg)
                st_d.flags = ao.res;
            end
            st_d.seq = alu_pkg::ST_EXEC;
          end
        end
      end
      alu_pkg::ST_EXEC:
      begin
        st_d.seq = alu_pkg::ST_IDLE;
      end
      alu_pkg::ST_MEM:
      begin
        if (MEM_ACK)
        begin
          st_d.result  = MEM_RDATA;
          st_d.mem.req = 1'b0;
          ptr_step     = 1'b1;
          ptr_down     = (cur_op == alu_pkg::OP_PROG_LOAD_DEC)
                      || (cur_op == alu_pkg::OP_EXT_LOAD_DEC);
          st_d.seq     = alu_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_d.seq = alu_pkg::ST_IDLE;
      end
    endcase
    // software register writes
    if (REG_WR)
    begin
      case (REG_ADDR)
        alu_pkg::A_FLAGS:   st_d.flags   = REG_WDATA;
        alu_pkg::A_OPER_A:  st_d.opa     = REG_WDATA;
        alu_pkg::A_OPER_B:  st_d.opb     = REG_WDATA;
        alu_pkg::A_WORKSEL: st_d.worksel = REG_WDATA;
        default:            st_d.opa     = st_d.opa;
      endcase
    end
    if (REG_RD)
    begin
      case (REG_ADDR)
        alu_pkg::A_FLAGS:   st_d.rdata = st_q.flags;
        alu_pkg::A_OPER_A:  st_d.rdata = st_q.opa;
        alu_pkg::A_OPER_B:  st_d.rdata = st_q.opb;
        alu_pkg::A_RESULT:  st_d.rdata = st_q.result;
        alu_pkg::A_WORKSEL: st_d.rdata = st_q.worksel;
        alu_pkg::A_PTR_HI:  st_d.rdata = {3'h0, ptr[alu_pkg::ADDR_W-1:8]};
        alu_pkg::A_PTR_LO:  st_d.rdata = ptr[7:0];
        alu_pkg::A_STATUS:  st_d.rdata = {5'h00, st_q.collide, st_q.seq};
        default:            st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      st_q         <= '0;
      st_q.seq     <= alu_pkg::ST_IDLE;
      st_q.flags   <= alu_pkg::FLAGS_RESET;
      st_q.worksel <= alu_pkg::WORK_BASE;
    end
    else
      st_q <= st_d;
  end

  addr_pair #(
    .AW (alu_pkg::ADDR_W)
  ) u_ptr (
    .CORE_CLK (CORE_CLK),
    .RST      (RST),
    .load_hi  (REG_WR && (REG_ADDR == alu_pkg::A_PTR_HI)),
    .load_lo  (REG_WR && (REG_ADDR == alu_pkg::A_PTR_LO)),
    .wdata    (REG_WDATA),
    .step     (ptr_step),
    .down     (ptr_down),
    .ptr      (ptr)
  );

  assign OP_READY  = (st_q.seq == alu_pkg::ST_IDLE);
  assign MEM_REQ   = st_q.mem;
  assign COND      = st_q.flags[alu_pkg::FLG_C:alu_pkg::FLG_V];
  assign REG_RDATA = st_q.rdata;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // reference sums of the issued operands
  logic [W:0] sadd;
  logic [W:0] usum;
  logic       add_v;
  assign sadd  = {st_q.opa[W-1], st_q.opa} + {b_val[W-1], b_val};
  assign usum  = {1'b0, st_q.opa} + {1'b0, b_val};
  assign add_v = (sadd[W] != sadd[W-1]);

  a_low_nibble_hold: assert property (
    (!REG_WR && !(OP_READY && OP_VALID && ao.wr && !ao.flg && eff_dst == alu_pkg::A_FLAGS))
      |=> ((st_q.flags & alu_pkg::LOW_NIB_MASK)
                 == ($past(st_q.flags) & alu_pkg::LOW_NIB_MASK)))
    else $error("low flag bits changed without a write");
  a_zero_flag: assert property (
    (OP_READY && OP_VALID && ao.flg && !REG_WR && !is_mem_op)
      |=> (st_q.flags[alu_pkg::FLG_Z] == ($past(ao.res) == '0)))
    else $error("zero flag does not match result");
  a_sign_flag: assert property (
    (OP_READY && OP_VALID && ao.flg && !REG_WR && !is_mem_op)
      |=> (st_q.flags[alu_pkg::FLG_S] == $past(ao.res[W-1])))
    else $error("sign flag does not match result msb");
  a_logic_ovf_clear: assert property (
    (OP_READY && OP_VALID && ao.logic_op && !REG_WR)
      |=> !st_q.flags[alu_pkg::FLG_V])
    else $error("overflow set after logic operation");
  a_load_keeps_flags: assert property (
    (OP_READY && OP_VALID && cur_op == alu_pkg::OP_LD && !REG_WR
     && eff_dst != alu_pkg::A_FLAGS) |=> $stable(st_q.flags))
    else $error("load changed flags");
  a_carry_set: assert property (
    (OP_READY && OP_VALID && cur_op == alu_pkg::OP_SET_CARRY && !REG_WR)
      |=> st_q.flags[alu_pkg::FLG_C])
    else $error("carry not set");
  a_carry_invert: assert property (
    (OP_READY && OP_VALID && cur_op == alu_pkg::OP_INVERT_CARRY && !REG_WR)
      |=> (st_q.flags[alu_pkg::FLG_C] != $past(st_q.flags[alu_pkg::FLG_C])))
    else $error("carry not inverted");
  a_cond_map: assert property (
    ##1 (COND == st_q.flags[7:4]))
    else $error("condition outputs differ from flags");
  a_ptr_step: assert property (
    (st_q.seq == alu_pkg::ST_MEM && MEM_ACK && !REG_WR)
      |=> (ptr == ($past(ptr_down) ? $past(ptr) - 13'h0001 : $past(ptr) + 13'h0001)))
    else $error("pointer did not step after load");
  a_mem_req_hold: assert property (
    (st_q.seq == alu_pkg::ST_MEM && !MEM_ACK) |=> MEM_REQ.req)
    else $error("memory request dropped early");
  a_add_overflow: assert property (
    (OP_READY && OP_VALID && cur_op == alu_pkg::OP_ADD && !REG_WR)
      |=> (st_q.flags[alu_pkg::FLG_V] == $past(add_v)))
    else $error("overflow wrong after add");
  a_add_carry: assert property (
    (OP_READY && OP_VALID && cur_op == alu_pkg::OP_ADD && !REG_WR)
      |=> (st_q.flags[alu_pkg::FLG_C] == $past(usum[W])))
    else $error("carry wrong after add");
  a_rotate_carry: assert property (
    (OP_READY && OP_VALID && cur_op == alu_pkg::OP_RR && !REG_WR)
      |=> (st_q.flags[alu_pkg::FLG_C] == $past(st_q.opa[0])))
    else $error("carry wrong after rotate right");
  a_mask_no_write: assert property (
    (OP_READY && OP_VALID && ao.flg && !ao.wr && !is_mem_op)
      |=> $stable(st_q.result))
    else $error("flag-only operation wrote a result");
  a_collide_flag: assert property (
    (OP_READY && OP_VALID && ao.wr && ao.flg && eff_dst == alu_pkg::A_FLAGS)
      |=> st_q.collide)
    else $error("flags collision not recorded");
  a_carry_clear: assert property (
    (OP_READY && OP_VALID && cur_op == alu_pkg::OP_CLEAR_CARRY && !REG_WR)
      |=> !st_q.flags[alu_pkg::FLG_C])
    else $error("carry not cleared");

  c_add_done: cover property (OP_VALID && OP_READY && cur_op == alu_pkg::OP_ADD);
  c_mem_load: cover property (st_q.seq == alu_pkg::ST_MEM ##1 MEM_ACK);
  c_collide:  cover property (st_q.collide);
  c_rotate:   cover property (OP_VALID && cur_op == alu_pkg::OP_ROTATE_LEFT_CARRY);

endmodule

// ---- logic/alu_pkg.sv ----
// shared constants and types of the alu and condition-flag block
package alu_pkg;

  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 13;
  localparam int unsigned REG_A_W = 8;
  localparam int unsigned WREG_W  = 4;

  // flag bit positions
  localparam int unsigned FLG_V = 4;
  localparam int unsigned FLG_S = 5;
  localparam int unsigned FLG_Z = 6;
  localparam int unsigned FLG_C = 7;
  localparam logic [7:0]  FLAGS_RESET  = 8'h00;
  localparam logic [7:0]  LOW_NIB_MASK = 8'h0F;

  // register port map
  localparam logic [7:0] A_FLAGS   = 8'h00;
  localparam logic [7:0] A_OPER_A  = 8'h01;
  localparam logic [7:0] A_OPER_B  = 8'h02;
  localparam logic [7:0] A_RESULT  = 8'h03;
  localparam logic [7:0] A_WORKSEL = 8'h04;
  localparam logic [7:0] A_PTR_HI  = 8'h05;
  localparam logic [7:0] A_PTR_LO  = 8'h06;
  localparam logic [7:0] A_STATUS  = 8'h07;
  localparam logic [7:0] WORK_BASE = 8'hC0;

  localparam int unsigned N_INSTR = 41;

  typedef enum logic [2:0] {
    AM_REG   = 3'h0,
    AM_IND   = 3'h1,
    AM_INDEX = 3'h2,
    AM_DIRECT= 3'h3,
    AM_REL   = 3'h4,
    AM_IMM   = 3'h5
  } addr_mode_e;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_ADD = 6'h01, OP_ADC = 6'h02, OP_SUB = 6'h03,
    OP_SBC = 6'h04, OP_CP  = 6'h05, OP_INC = 6'h06, OP_DEC = 6'h07,
    OP_AND = 6'h08, OP_OR  = 6'h09, OP_XOR = 6'h0A, OP_COM = 6'h0B,
    OP_MASK_TEST = 6'h0C, OP_INV_MASK_TEST = 6'h0D,
    OP_RL = 6'h0E, OP_RR = 6'h0F, OP_ROTATE_LEFT_CARRY = 6'h10,
    OP_ROTATE_RIGHT_CARRY = 6'h11, OP_ARITH_SHIFT_RIGHT = 6'h12,
    OP_SET_CARRY = 6'h13, OP_CLEAR_CARRY = 6'h14, OP_INVERT_CARRY = 6'h15,
    OP_LD = 6'h16, OP_CLR = 6'h17,
    OP_PROG_LOAD_INC = 6'h18, OP_PROG_LOAD_DEC = 6'h19,
    OP_EXT_LOAD_INC = 6'h1A, OP_EXT_LOAD_DEC = 6'h1B
  } alu_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_MEM  = 2'b11
  } seq_e;

  typedef struct packed {
    logic [DATA_W-1:0] res;
    logic              c;
    logic              v;
    logic              wr;
    logic              flg;
    logic              logic_op;
  } alu_out_s;

  typedef struct packed {
    logic              req;
    logic              prog;
    logic [ADDR_W-1:0] addr;
  } mem_req_s;

endpackage

// ---- logic/alu_core.sv ----
// combinational arithmetic, logic and rotate unit
`timescale 1ns/10ps
module alu_core #(
  parameter int unsigned W = alu_pkg::DATA_W
) (
  // operation
  input  wire alu_pkg::alu_op_e op,
  input  wire logic [W-1:0]     a,
  input  wire logic [W-1:0]     b,
  input  wire logic             c_in,
  // result
  output alu_pkg::alu_out_s     o
);

  function automatic logic [W:0] addc(input logic [W-1:0] x, input logic [W-1:0] y,
                                      input logic ci);
    addc = {1'b0, x} + {1'b0, y} + {{W{1'b0}}, ci};
  endfunction

  function automatic logic ovf(input logic xa, input logic yb, input logic r);
    ovf = (xa == yb) && (r != xa);
  endfunction

  logic [W:0] sum;

  always_comb
  begin
    o          = '0;
    o.res      = a;
    o.c        = c_in;
    sum        = '0;
    case (op)
      alu_pkg::OP_ADD, alu_pkg::OP_ADC, alu_pkg::OP_INC:
      begin
        // carry out of bit 7 (INC keeps the carry), signed range check
        sum   = (op == alu_pkg::OP_INC) ? addc(a, {{(W-1){1'b0}}, 1'b1}, 1'b0)
              : addc(a, b, (op == alu_pkg::OP_ADC) && c_in);
        o.res = sum[W-1:0];
        o.c   = (op == alu_pkg::OP_INC) ? c_in : sum[W];
        o.v   = ovf(a[W-1], (op == alu_pkg::OP_INC) ? 1'b0 : b[W-1], sum[W-1]);
        o.wr  = 1'b1;
        o.flg = 1'b1;
      end
      alu_pkg::OP_SUB, alu_pkg::OP_SBC, alu_pkg::OP_CP, alu_pkg::OP_DEC:
      begin
        // borrow out of bit 7 is the inverted adder carry; DEC keeps the carry
        sum   = (op == alu_pkg::OP_DEC) ? addc(a, {W{1'b1}}, 1'b0)
              : addc(a, ~b, !((op == alu_pkg::OP_SBC) && c_in));
        o.res = sum[W-1:0];
        o.c   = (op == alu_pkg::OP_DEC) ? c_in : !sum[W];
        o.v   = ovf(a[W-1], (op == alu_pkg::OP_DEC) ? 1'b1 : ~b[W-1], sum[W-1]);
        o.wr  = (op != alu_pkg::OP_CP);
        o.flg = 1'b1;
      end
      alu_pkg::OP_AND, alu_pkg::OP_OR, alu_pkg::OP_XOR, alu_pkg::OP_COM:
      begin
        case (op)
          alu_pkg::OP_AND: o.res = a & b;
          alu_pkg::OP_OR:  o.res = a | b;
          alu_pkg::OP_XOR: o.res = a ^ b;
          default:         o.res = ~a;
        endcase
        o.wr       = 1'b1;
        o.flg      = 1'b1;
        o.logic_op = 1'b1;
      end
      alu_pkg::OP_MASK_TEST, alu_pkg::OP_INV_MASK_TEST:
      begin
        o.res      = ((op == alu_pkg::OP_INV_MASK_TEST) ? ~a : a) & b;
        o.flg      = 1'b1;
        o.logic_op = 1'b1;
      end
      alu_pkg::OP_RL:
      begin
        o.res = {a[W-2:0], a[W-1]};
        o.c   = a[W-1];
        o.v   = a[W-1] ^ a[W-2];
        o.wr  = 1'b1;
        o.flg = 1'b1;
      end
      alu_pkg::OP_ROTATE_LEFT_CARRY:
      begin
        o.res = {a[W-2:0], c_in};
        o.c   = a[W-1];
        o.v   = a[W-1] ^ a[W-2];
        o.wr  = 1'b1;
        o.flg = 1'b1;
      end
      alu_pkg::OP_RR:
      begin
        o.res = {a[0], a[W-1:1]};
        o.c   = a[0];
        o.v   = a[0] ^ a[W-1];
        o.wr  = 1'b1;
        o.flg = 1'b1;
      end
      alu_pkg::OP_ROTATE_RIGHT_CARRY:
      begin
        o.res = {c_in, a[W-1:1]};
        o.c   = a[0];
        o.v   = c_in ^ a[W-1];
        o.wr  = 1'b1;
        o.flg = 1'b1;
      end
      alu_pkg::OP_ARITH_SHIFT_RIGHT:
      begin
        o.res = {a[W-1], a[W-1:1]};
        o.c   = a[0];
        o.wr  = 1'b1;
        o.flg = 1'b1;
      end
      alu_pkg::OP_LD:
      begin
        o.res = b;
        o.wr  = 1'b1;
      end
      alu_pkg::OP_CLR:
      begin
        o.res = '0;
        o.wr  = 1'b1;
      end
      default:
      begin
        o.res = a;
      end
    endcase
  end

endmodule

// ---- logic/addr_pair.sv ----
// 13-bit register-pair address with post increment or decrement
`timescale 1ns/10ps
module addr_pair #(
  parameter int unsigned AW = alu_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic          CORE_CLK,
  input  wire logic          RST,
  // control
  input  wire logic          load_hi,
  input  wire logic          load_lo,
  input  wire logic [7:0]    wdata,
  input  wire logic          step,
  input  wire logic          down,
  // pointer
  output logic      [AW-1:0] ptr
);

  typedef struct packed {
    logic [AW-1:0] ptr;
  } st_s;

  st_s st_q;
  st_s st_d;

  always_comb
  begin
    st_d = st_q;
    if (load_hi)
      st_d.ptr[AW-1:8] = wdata[AW-9:0];
    if (load_lo)
      st_d.ptr[7:0] = wdata;
    // address change comes after the transfer that used it
    if (step)
      st_d.ptr = down ? st_q.ptr - AW'(1) : st_q.ptr + AW'(1);
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign ptr = st_q.ptr;

endmodule

// ---- dv/tb.sv ----
// self-checking testbench of the alu and condition-flag block
`timescale 1ns/10ps
module tb;
  logic                CORE_CLK;
  logic                RST;
  logic                OP_VALID;
  logic                OP_DST_WORK;
  logic                OP_READY;
  logic                MEM_ACK;
  logic                REG_WR;
  logic                REG_RD;
  alu_pkg::alu_op_e    OP_CODE;
  alu_pkg::addr_mode_e OP_MODE;
  logic [7:0]          OP_DST;
  logic [7:0]          OP_SRC;
  logic [7:0]          MEM_RDATA;
  logic [7:0]          REG_ADDR;
  logic [7:0]          REG_WDATA;
  logic [7:0]          REG_RDATA;
  alu_pkg::mem_req_s   MEM_REQ;
  logic [3:0]          COND;
  int                  error_cnt;
  int                  samples_checked;
  int                  i;
  int                  seed;
  logic [7:0]          f;
  logic [7:0]          q;
  logic [7:0]          last_res;
  alu_pkg::alu_op_e    cops [3];

  alu_flags_top dut (
    .CORE_CLK    (CORE_CLK),
    .RST         (RST),
    .OP_VALID    (OP_VALID),
    .OP_CODE     (OP_CODE),
    .OP_MODE     (OP_MODE),
    .OP_DST      (OP_DST),
    .OP_SRC      (OP_SRC),
    .OP_DST_WORK (OP_DST_WORK),
    .OP_READY    (OP_READY),
    .MEM_REQ     (MEM_REQ),
    .MEM_ACK     (MEM_ACK),
    .MEM_RDATA   (MEM_RDATA),
    .COND        (COND),
    .REG_ADDR    (REG_ADDR),
    .REG_WDATA   (REG_WDATA),
    .REG_WR      (REG_WR),
    .REG_RD      (REG_RD),
    .REG_RDATA   (REG_RDATA)
  );

  initial
  begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  // ----------------------------------------------------------------
  // expectation and bus tasks
  // ----------------------------------------------------------------
  // returns {C,Z,S,V,result}
  function automatic logic [11:0] model(input alu_pkg::alu_op_e op,
                                        input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
    logic [8:0] t;
    logic       c;
    logic       v;
    logic       rot;
    c = ci;
    v = 1'b0;
    rot = 1'b1;
    case (op)
      alu_pkg::OP_ADD, alu_pkg::OP_ADC:
      begin
        t = {1'b0, a} + {1'b0, b} + {8'h00, op == alu_pkg::OP_ADC && ci};
        c = t[8];
        v = (a[7] == b[7]) && (t[7] != a[7]);
        rot = 1'b0;
      end
      alu_pkg::OP_SUB, alu_pkg::OP_SBC, alu_pkg::OP_CP:
      begin
        t = {1'b0, a} - {1'b0, b} - {8'h00, op == alu_pkg::OP_SBC && ci};
        c = t[8];
        v = (a[7] != b[7]) && (t[7] != a[7]);
        rot = 1'b0;
      end
      alu_pkg::OP_INC, alu_pkg::OP_DEC:
      begin
        t = (op == alu_pkg::OP_INC) ? {1'b0, a} + 9'h001 : {1'b0, a} - 9'h001;
        v = (op == alu_pkg::OP_INC) ? a == 8'h7F : a == 8'h80;
        rot = 1'b0;
      end
      alu_pkg::OP_RL:                 {c, t} = {a[7], 1'b0, a[6:0], a[7]};
      alu_pkg::OP_ROTATE_LEFT_CARRY:  {c, t} = {a[7], 1'b0, a[6:0], ci};
      alu_pkg::OP_RR:                 {c, t} = {a[0], 1'b0, a[0], a[7:1]};
      alu_pkg::OP_ROTATE_RIGHT_CARRY: {c, t} = {a[0], 1'b0, ci, a[7:1]};
      alu_pkg::OP_ARITH_SHIFT_RIGHT:  {c, t} = {a[0], 1'b0, a[7], a[7:1]};
      default:
      begin
        rot = 1'b0;
        case (op)
          alu_pkg::OP_AND:       t = {1'b0, a & b};
          alu_pkg::OP_OR:        t = {1'b0, a | b};
          alu_pkg::OP_XOR:       t = {1'b0, a ^ b};
          alu_pkg::OP_MASK_TEST: t = {1'b0, a & b};
          alu_pkg::OP_COM:       t = {1'b0, ~a};
          alu_pkg::OP_LD:        t = {1'b0, b};
          alu_pkg::OP_CLR:       t = 9'h000;
          default:               t = {1'b0, ~a & b};
        endcase
      end
    endcase
    if (rot)
      v = a[7] ^ t[7];
    return {c, t[7:0] == 8'h00, t[7], v, t[7:0]};
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD   <= 1'b0;
    #1 d = REG_RDATA;
  endtask

  task automatic issue(input alu_pkg::alu_op_e op);
    @(posedge CORE_CLK);
    OP_CODE  <= op;
    OP_VALID <= 1'b1;
    @(posedge CORE_CLK);
    OP_VALID <= 1'b0;
  endtask

  task automatic wait_ready;
    int n = 0;
    do
    begin
      @(posedge CORE_CLK);
      #1 n++;
    end while (OP_READY !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      error_cnt++;
      end_sim;
    end
  endtask

  task automatic run_alu(input alu_pkg::alu_op_e op, input logic [7:0] a,
                         input logic [7:0] b, input logic [7:0] fl);
    logic [11:0] e;
    int          m;
    e = model(op, a, b, fl[7]);
    if (op == alu_pkg::OP_LD || op == alu_pkg::OP_CLR)
      e[11:8] = fl[7:4];
    m = $unsigned($random(seed)) % 3;
    wr(alu_pkg::A_FLAGS, fl);
    wr(alu_pkg::A_OPER_B, m == 0 ? b : m == 1 ? ~b : b - 8'h11);
    OP_MODE <= m == 0 ? alu_pkg::AM_REG : m == 1 ? alu_pkg::AM_IMM : alu_pkg::AM_INDEX;
    OP_SRC  <= m == 0 ? ~b : m == 1 ? b : 8'h11;
    wr(alu_pkg::A_OPER_A, a);
    issue(op);
    wait_ready;
    if (op != alu_pkg::OP_MASK_TEST && op != alu_pkg::OP_INV_MASK_TEST && op != alu_pkg::OP_CP)
      last_res = e[7:0];
    chk("cond", {4'h0, COND}, {4'h0, e[11:8]});
    rd(alu_pkg::A_FLAGS, q);
    chk("flags", q, {e[11:8], fl[3:0]});
    rd(alu_pkg::A_RESULT, q);
    chk("result", q, last_res);
  endtask

  task automatic mem_op(input alu_pkg::alu_op_e op, input logic [7:0] hi, input logic [7:0] lo,
                        input logic prg, input logic [7:0] ehi, input logic [7:0] elo);
    logic [7:0] dat;
    int         n = 0;
    dat = 8'($random(seed));
    wr(alu_pkg::A_PTR_HI, hi);
    wr(alu_pkg::A_PTR_LO, lo);
    wr(alu_pkg::A_FLAGS, 8'h5A);
    issue(op);
    do
    begin
      @(posedge CORE_CLK);
      #1 n++;
    end while (MEM_REQ.req !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      error_cnt++;
      end_sim;
    end
    chk("mem space", {7'h00, MEM_REQ.prog}, {7'h00, prg});
    chk("mem addr lo", MEM_REQ.addr[7:0], lo);
    chk("mem addr hi", {3'h0, MEM_REQ.addr[12:8]}, {3'h0, hi[4:0]});
    @(posedge CORE_CLK);
    MEM_ACK   <= 1'b1;
    MEM_RDATA <= dat;
    @(posedge CORE_CLK);
    MEM_ACK   <= 1'b0;
    MEM_RDATA <= ~dat;
    wait_ready;
    rd(alu_pkg::A_FLAGS, q);
    chk("load flags", q, 8'h5A);
    rd(alu_pkg::A_RESULT, q);
    chk("load data", q, dat);
    rd(alu_pkg::A_PTR_HI, q);
    chk("ptr hi", q, ehi);
    rd(alu_pkg::A_PTR_LO, q);
    chk("ptr lo", q, elo);
  endtask

  task end_sim;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'h8E3B3726;
    error_cnt = 0;
    samples_checked = 0;
    {RST, OP_VALID, OP_DST_WORK, MEM_ACK, REG_WR, REG_RD} = 6'b100000;
    OP_CODE = alu_pkg::OP_NOP;
    OP_MODE = alu_pkg::AM_REG;
    OP_DST = alu_pkg::A_RESULT;
    {OP_SRC, MEM_RDATA, REG_ADDR, REG_WDATA} = 32'h0;
    last_res = 8'h00;
    cops = '{alu_pkg::OP_SET_CARRY, alu_pkg::OP_CLEAR_CARRY, alu_pkg::OP_INVERT_CARRY};
    repeat (16) @(posedge CORE_CLK);
    RST <= 1'b0;
    rd(alu_pkg::A_FLAGS, q);
    chk("flags reset", q, alu_pkg::FLAGS_RESET);
    rd(alu_pkg::A_WORKSEL, q);
    chk("worksel reset", q, 8'hC0);
    wr(8'h20, 8'h55);
    rd(8'h20, q);
    chk("unmapped", q, 8'h00);
    $display("test reset done");
    run_alu(alu_pkg::OP_ADD, 8'h7F, 8'h01, 8'h0A);
    run_alu(alu_pkg::OP_SUB, 8'h80, 8'h01, 8'h05);
    run_alu(alu_pkg::OP_ADD, 8'hFF, 8'h01, 8'h00);
    run_alu(alu_pkg::OP_SUB, 8'h00, 8'h01, 8'hF3);
    run_alu(alu_pkg::OP_AND, 8'hF0, 8'h0F, 8'hFF);
    run_alu(alu_pkg::OP_INV_MASK_TEST, 8'hFF, 8'h80, 8'h10);
    run_alu(alu_pkg::OP_INC, 8'h7F, 8'h00, 8'h00);
    run_alu(alu_pkg::OP_DEC, 8'h80, 8'h00, 8'hFF);
    run_alu(alu_pkg::OP_LD, 8'h12, 8'hA5, 8'h3C);
    run_alu(alu_pkg::OP_CLR, 8'h12, 8'h34, 8'hC0);
    // working number 0 over base 00 lands on the flags register
    wr(alu_pkg::A_WORKSEL, 8'h00);
    OP_DST_WORK <= 1'b1;
    OP_DST      <= 8'hF0;
    run_alu(alu_pkg::OP_ADD, 8'h40, 8'h40, 8'h09);
    rd(alu_pkg::A_STATUS, q);
    chk("collide", q, 8'h04);
    OP_DST_WORK <= 1'b0;
    OP_DST      <= alu_pkg::A_RESULT;
    for (i = 0; i < 60; i++)
      run_alu(alu_pkg::alu_op_e'(6'($unsigned($random(seed)) % 18) + 6'h01),
              8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
    $display("test alu done");
    for (i = 0; i < 3; i++)
    begin
      f = 8'($random(seed));
      wr(alu_pkg::A_FLAGS, f);
      issue(cops[i]);
      wait_ready;
      rd(alu_pkg::A_FLAGS, q);
      chk("carry op", q, i == 0 ? f | 8'h80 : i == 1 ? f & 8'h7F : f ^ 8'h80);
    end
    $display("test carry done");
    mem_op(alu_pkg::OP_PROG_LOAD_INC, 8'h1F, 8'hFF, 1'b1, 8'h00, 8'h00);
    mem_op(alu_pkg::OP_EXT_LOAD_DEC, 8'h00, 8'h00, 1'b0, 8'h1F, 8'hFF);
    mem_op(alu_pkg::OP_PROG_LOAD_DEC, 8'h12, 8'h00, 1'b1, 8'h11, 8'hFF);
    mem_op(alu_pkg::OP_EXT_LOAD_INC, 8'h03, 8'h7F, 1'b0, 8'h03, 8'h80);
    $display("test load done");
    end_sim;
  end
endmodule
